//--- design/bplis_defines.svh
/*
  Constants of the backplane line interface sequencer: timing, register
  indices, field positions and reset values.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef BPLIS_DEFINES_SVH
`define BPLIS_DEFINES_SVH

`define BPLIS_CLK_MHZ        100
`define BPLIS_PULSE_NS       1600
`define BPLIS_PULSE_CYC      ((`BPLIS_PULSE_NS * `BPLIS_CLK_MHZ + 999) / 1000)
`define BPLIS_BIT_NS         3200
`define BPLIS_BIT_CYC        ((`BPLIS_BIT_NS * `BPLIS_CLK_MHZ) / 1000)
`define BPLIS_FAST_HZ        625000
`define BPLIS_FAST_CYC       ((`BPLIS_CLK_MHZ * 1000000) / `BPLIS_FAST_HZ)
`define BPLIS_SLOW_HZ        312500
`define BPLIS_SLOW_CYC       ((`BPLIS_CLK_MHZ * 1000000) / `BPLIS_SLOW_HZ)
`define BPLIS_ROM_DEPTH      544

`define BPLIS_IDX_DIAG       6'h01
`define BPLIS_IDX_NODE_CTRL  6'h06
`define BPLIS_IDX_LINK_OPT   6'h07
`define BPLIS_IDX_IRQ_STAT   6'h08
`define BPLIS_IDX_IRQ_MASK   6'h09
`define BPLIS_IDX_TX_DATA    6'h0A
`define BPLIS_IDX_RX_DATA    6'h0B
`define BPLIS_IDX_RECON_LIM  6'h0C
`define BPLIS_IDX_SEQ_PC     6'h0D

`define BPLIS_DIAG_RECON_BIT 7
`define BPLIS_DIAG_RXACT_BIT 5
`define BPLIS_NC_TXEN_BIT    5
`define BPLIS_NC_BP_BIT      2
`define BPLIS_LO_STYLE_BIT   7
`define BPLIS_IRQ_TX_BIT     0
`define BPLIS_IRQ_RX_BIT     1
`define BPLIS_IRQ_RECON_BIT  2

`define BPLIS_NC_RESET       8'h04
`define BPLIS_LO_RESET       8'h00
`define BPLIS_MASK_RESET     3'h0
`define BPLIS_RECON_RESET    8'h10

`endif

//--- design/bplis_pkg.sv
/*
  Types of the backplane line interface sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bplis_pkg;

  typedef enum logic [1:0] {
    BPLIS_OP_WAIT = 2'h0,
    BPLIS_OP_JUMP = 2'h1,
    BPLIS_OP_STEP = 2'h2,
    BPLIS_OP_RSVD = 2'h3
  } bplis_op_t;

  typedef enum logic [3:0] {
    BPLIS_SEQ_FETCH_OP  = 4'h1,
    BPLIS_SEQ_FETCH_IMM = 4'h2,
    BPLIS_SEQ_EXEC      = 4'h4,
    BPLIS_SEQ_WAIT      = 4'h8
  } bplis_seq_t;

endpackage

//--- design/bplis_line_tx.sv
/*
  Serial encoder: eight bits LSB first, one bit per interval, a one sent as
  a low pulse of fixed width at the start of its interval.
  Assumes bit_tick marks each interval start, one cycle wide.
*/
`timescale 1ns/10ps
module bplis_line_tx #(
  parameter int unsigned PULSE_CYC = 160
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       bit_tick,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            done,
  output logic            pulse_low
);

  logic [7:0]  shreg;
  logic [3:0]  bits_left;
  logic [15:0] pulse_cnt;
  logic        next_busy;
  logic        next_done;
  logic [7:0]  next_shreg;
  logic [3:0]  next_bits_left;
  logic [15:0] next_pulse_cnt;

  always_comb
  begin
    next_busy      = busy;
    next_done      = 1'b0;
    next_shreg     = shreg;
    next_bits_left = bits_left;
    next_pulse_cnt = (pulse_cnt != 16'h0000) ? pulse_cnt - 16'h0001 : 16'h0000;
    if (!busy && start)
    begin
      next_busy      = 1'b1;
      next_shreg     = data;
      next_bits_left = 4'h8;
    end
    else if (busy && bit_tick)
    begin
      if (bits_left != 4'h0)
      begin
        if (shreg[0])
          next_pulse_cnt = PULSE_CYC[15:0];
        next_shreg     = {1'b0, shreg[7:1]};
        next_bits_left = bits_left - 4'h1;
      end
      else
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy      <= 1'b0;
      done      <= 1'b0;
      shreg     <= 8'h00;
      bits_left <= 4'h0;
      pulse_cnt <= 16'h0000;
    end
    else
    begin
      busy      <= next_busy;
      done      <= next_done;
      shreg     <= next_shreg;
      bits_left <= next_bits_left;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  assign pulse_low = (pulse_cnt != 16'h0000);

endmodule

//--- design/bplis_line_rx.sv
/*
  Serial decoder: a falling edge opens a byte and its first interval; each of the eight intervals
  yields a one if a low pulse began in it, else a zero; LSB first.
  Assumes the receive pin is already synchronous to the clock.
*/
`timescale 1ns/10ps
module bplis_line_rx #(
  parameter int unsigned BIT_CYC = 320
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       rx_in,
  output logic            pulse_seen,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);

  logic        prev;
  logic        active;
  logic        seen;
  logic [15:0] cnt;
  logic [2:0]  nbits;
  logic [7:0]  shreg;
  logic        fall;
  logic        next_active;
  logic        next_seen;
  logic [15:0] next_cnt;
  logic [2:0]  next_nbits;
  logic [7:0]  next_shreg;
  logic        next_valid;
  logic [7:0]  next_byte;

  assign fall       = prev && !rx_in;
  assign pulse_seen = fall;

  always_comb
  begin
    next_active = active;
    next_seen   = seen;
    next_cnt    = cnt;
    next_nbits  = nbits;
    next_shreg  = shreg;
    next_valid  = 1'b0;
    next_byte   = byte_data;
    if (!active)
    begin
      if (fall)
      begin
        next_active = 1'b1;
        next_seen   = 1'b1;
        // The edge's own cycle is the first of its interval, so the next
        // pulse, one interval later, opens the following bit
        next_cnt    = 16'h0001;
        next_nbits  = 3'h0;
      end
    end
    else
    begin
      next_cnt = cnt + 16'h0001;
      if (fall)
        next_seen = 1'b1;
      if (cnt == 16'(BIT_CYC - 1))
      begin
        next_shreg = {seen || fall, shreg[7:1]};
        next_seen  = 1'b0;
        next_cnt   = 16'h0000;
        next_nbits = nbits + 3'h1;
        if (nbits == 3'h7)
        begin
          next_active = 1'b0;
          next_valid  = 1'b1;
          next_byte   = {seen || fall, shreg[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev       <= 1'b1;
      active     <= 1'b0;
      seen       <= 1'b0;
      cnt        <= 16'h0000;
      nbits      <= 3'h0;
      shreg      <= 8'h00;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end
    else
    begin
      prev       <= rx_in;
      active     <= next_active;
      seen       <= next_seen;
      cnt        <= next_cnt;
      nbits      <= next_nbits;
      shreg      <= next_shreg;
      byte_valid <= next_valid;
      byte_data  <= next_byte;
    end
  end

endmodule

//--- design/bplis_top.sv
/*
  Backplane line interface and microsequencer, reached over APB.
  Assumes one 100 MHz clock, synchronous active-high reset, pins already
  synchronous, and the board resolving open-drain and strap wiring.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "bplis_defines.svh"

// Contract
// - Drive style selectable, open-drain by default
// - Logic one sent as 1.6 us low pulse
// - Receive low pulse is one, none zero
// - Aux clock output active in backplane mode; kept off here when the strap is grounded
// - Differential data only while enable asserted
// - Reset keeps transmitter and all outputs inactive
// - Aux pin strap sets enable polarity; here only in backplane mode, else active low
// - Derive 625 kHz and 312.5 kHz ticks
// - PC at fast tick, execute at slow
// - Fetch 544x8 ROM into opcode, immediate
// - No-op waits, holding program counter
// - Jump loads program counter from ROM
// - Reconfig timeout clears PC, sets flag
module bplis_top #(
  parameter int unsigned PULSE_CYC = `BPLIS_PULSE_CYC,
  parameter int unsigned BIT_CYC   = `BPLIS_BIT_CYC,
  parameter int unsigned FAST_CYC  = `BPLIS_FAST_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             line_drive_out,
  output logic             line_drive_oe,
  input  wire logic        line_receive_in,
  output logic             aux_clock_out,
  output logic             aux_clock_oe,
  input  wire logic        aux_clock_in,
  output logic             driver_enable_out
);

  if (PULSE_CYC < 1 || PULSE_CYC >= BIT_CYC || BIT_CYC > 65535 || FAST_CYC < 2 ||
      FAST_CYC > 65535)
  begin : g_bad_param
    $error("bplis_top: timing parameters out of range");
  end

  // Registers and state
  logic [7:0]  node_control;
  logic [7:0]  link_options;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [7:0]  recon_limit;
  logic        self_reconfig_flag;
  logic        rx_activity;
  logic [7:0]  tx_byte;
  logic        strap_gnd;
  logic [15:0] bit_cnt;
  logic [15:0] fast_cnt;
  logic        slow_phase;
  logic [9:0]  pc;
  logic [7:0]  opcode_reg;
  logic [7:0]  imm_reg;
  logic [7:0]  wait_cnt;
  logic [15:0] recon_cnt;
  bplis_pkg::bplis_seq_t seq;

  logic [7:0]  next_node_control;
  logic [7:0]  next_link_options;
  logic [2:0]  next_irq_status;
  logic [2:0]  next_irq_mask;
  logic [7:0]  next_recon_limit;
  logic        next_self_reconfig_flag;
  logic        next_rx_activity;
  logic [7:0]  next_tx_byte;
  logic        next_strap_gnd;
  logic [15:0] next_bit_cnt;
  logic [15:0] next_fast_cnt;
  logic        next_slow_phase;
  logic [9:0]  next_pc;
  logic [7:0]  next_opcode_reg;
  logic [7:0]  next_imm_reg;
  logic [7:0]  next_wait_cnt;
  logic [15:0] next_recon_cnt;
  bplis_pkg::bplis_seq_t next_seq;
  logic        next_line_out;
  logic        next_line_oe;
  logic        next_aux_out;
  logic        next_aux_oe;
  logic        next_drv_en;

  logic        wr_en;
  logic        rd_en;
  logic [5:0]  idx;
  logic        mapped;
  logic        bit_tick;
  logic        fast_tick;
  logic        slow_tick;
  logic        recon_expire;
  logic        tx_start;
  logic        tx_busy;
  logic        tx_done;
  logic        tx_pulse_low;
  logic        rx_pulse;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        backplane;
  logic        push_pull;
  logic        tx_allowed;
  logic        hi_pol;
  logic [7:0]  rom_word;

  bplis_line_tx #(
    .PULSE_CYC (PULSE_CYC)
  ) u_tx (
    .clock     (clock),
    .rst       (rst),
    .bit_tick  (bit_tick),
    .start     (tx_start),
    .data      (pwdata[7:0]),
    .busy      (tx_busy),
    .done      (tx_done),
    .pulse_low (tx_pulse_low)
  );

  bplis_line_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .clock      (clock),
    .rst        (rst),
    .rx_in      (line_receive_in),
    .pulse_seen (rx_pulse),
    .byte_valid (rx_valid),
    .byte_data  (rx_byte)
  );

  // Microprogram: wait, step, jump back to zero; words past the loop are waits
  function automatic logic [7:0] bplis_rom(input logic [9:0] a);
    logic [7:0] w;
    w = 8'h00;
    case (a)
      10'h000: w = 8'h00;
      10'h001: w = 8'h03;
      10'h002: w = 8'h80;
      10'h003: w = 8'h00;
      10'h004: w = 8'h40;
      10'h005: w = 8'h00;
      default: w = 8'h00;
    endcase
    return w;
  endfunction

  assign pready     = 1'b1;
  assign idx        = paddr[7:2];
  assign wr_en      = psel && penable && pwrite && mapped;
  assign rd_en      = psel && penable && !pwrite && mapped;
  assign backplane  = node_control[`BPLIS_NC_BP_BIT];
  assign push_pull  = link_options[`BPLIS_LO_STYLE_BIT];
  assign tx_allowed = node_control[`BPLIS_NC_TXEN_BIT];
  assign hi_pol     = strap_gnd && backplane;
  assign bit_tick   = (bit_cnt == 16'h0000);
  assign fast_tick  = (fast_cnt == 16'h0000);
  assign slow_tick  = fast_tick && slow_phase;
  assign tx_start   = wr_en && (idx == `BPLIS_IDX_TX_DATA) && !tx_busy && tx_allowed;
  assign rom_word   = bplis_rom(pc);
  assign recon_expire = slow_tick && (recon_cnt >= {recon_limit, 8'h00});
  assign irq        = |(irq_status & irq_mask);

  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (idx)
      `BPLIS_IDX_DIAG:      prdata[7:0] = {self_reconfig_flag, 1'b0, rx_activity, 5'h00};
      `BPLIS_IDX_NODE_CTRL: prdata[7:0] = node_control;
      `BPLIS_IDX_LINK_OPT:  prdata[7:0] = link_options;
      `BPLIS_IDX_IRQ_STAT:  prdata[2:0] = irq_status;
      `BPLIS_IDX_IRQ_MASK:  prdata[2:0] = irq_mask;
      `BPLIS_IDX_TX_DATA:   prdata[8:0] = {tx_busy, tx_byte};
      `BPLIS_IDX_RX_DATA:   prdata[7:0] = rx_byte;
      `BPLIS_IDX_RECON_LIM: prdata[7:0] = recon_limit;
      `BPLIS_IDX_SEQ_PC:    prdata[9:0] = pc;
      default:              mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
    pslverr = psel && penable && !mapped;
  end

  // Register file and status
  always_comb
  begin
    next_node_control = node_control;
    next_link_options = link_options;
    next_irq_mask     = irq_mask;
    next_recon_limit  = recon_limit;
    next_tx_byte      = tx_start ? pwdata[7:0] : tx_byte;
    next_irq_status   = irq_status;
    next_self_reconfig_flag = self_reconfig_flag;
    next_rx_activity  = rx_activity;
    // Strap tracked through reset, frozen from the first cycle after
    // strap caught at reset
    next_strap_gnd    = rst ? !aux_clock_in : strap_gnd;
    if (wr_en)
    begin
      case (idx)
        `BPLIS_IDX_NODE_CTRL: next_node_control = pwdata[7:0];
        `BPLIS_IDX_LINK_OPT:  next_link_options = pwdata[7:0];
        `BPLIS_IDX_IRQ_MASK:  next_irq_mask     = pwdata[2:0];
        `BPLIS_IDX_RECON_LIM: next_recon_limit  = pwdata[7:0];
        `BPLIS_IDX_IRQ_STAT:  next_irq_status   = irq_status & ~pwdata[2:0];
        default:              next_irq_status   = next_irq_status;
      endcase
    end
    // Reading the diagnostic flags clears them; a new event still wins
    if (rd_en && idx == `BPLIS_IDX_DIAG)
    begin
      next_self_reconfig_flag = 1'b0;
      next_rx_activity        = 1'b0;
    end
    if (rx_pulse)
      next_rx_activity = 1'b1;
    if (recon_expire)
    begin
      next_self_reconfig_flag = 1'b1;
      next_irq_status[`BPLIS_IRQ_RECON_BIT] = 1'b1;
    end
    if (tx_done)
      next_irq_status[`BPLIS_IRQ_TX_BIT] = 1'b1;
    if (rx_valid)
      next_irq_status[`BPLIS_IRQ_RX_BIT] = 1'b1;
  end

  // Timebase and microsequencer
  always_comb
  begin
    next_bit_cnt   = (bit_cnt == 16'(BIT_CYC - 1)) ? 16'h0000 : bit_cnt + 16'h0001;
    next_fast_cnt  = (fast_cnt == 16'(FAST_CYC - 1)) ? 16'h0000 : fast_cnt + 16'h0001;
    next_slow_phase = fast_tick ? !slow_phase : slow_phase;
    next_pc        = pc;
    next_opcode_reg = opcode_reg;
    next_imm_reg   = imm_reg;
    next_wait_cnt  = wait_cnt;
    next_seq       = seq;
    next_recon_cnt = rx_pulse ? 16'h0000 : (slow_tick ? recon_cnt + 16'h0001 : recon_cnt);
    if (recon_expire)
    begin
      next_pc        = 10'h000;
      next_seq       = bplis_pkg::BPLIS_SEQ_FETCH_OP;
      next_recon_cnt = 16'h0000;
    end
    else if (fast_tick)
    begin
      case (seq)
        bplis_pkg::BPLIS_SEQ_FETCH_OP:
        begin
          next_opcode_reg = rom_word;
          next_pc  = (pc == 10'(`BPLIS_ROM_DEPTH - 1)) ? 10'h000 : pc + 10'h001;
          next_seq = bplis_pkg::BPLIS_SEQ_FETCH_IMM;
        end
        bplis_pkg::BPLIS_SEQ_FETCH_IMM:
        begin
          next_imm_reg = rom_word;
          next_pc  = (pc == 10'(`BPLIS_ROM_DEPTH - 1)) ? 10'h000 : pc + 10'h001;
          next_seq = bplis_pkg::BPLIS_SEQ_EXEC;
        end
        bplis_pkg::BPLIS_SEQ_EXEC:
        begin
          if (slow_tick)
          begin
            case (bplis_pkg::bplis_op_t'(opcode_reg[7:6]))
              bplis_pkg::BPLIS_OP_JUMP:
              begin
                next_pc  = {opcode_reg[1:0], imm_reg};
                next_seq = bplis_pkg::BPLIS_SEQ_FETCH_OP;
              end
              bplis_pkg::BPLIS_OP_WAIT:
              begin
                next_wait_cnt = imm_reg;
                next_seq      = bplis_pkg::BPLIS_SEQ_WAIT;
              end
              default:
                next_seq = bplis_pkg::BPLIS_SEQ_FETCH_OP;
            endcase
          end
        end
        bplis_pkg::BPLIS_SEQ_WAIT:
        begin
          if (slow_tick)
          begin
            if (wait_cnt == 8'h00)
              next_seq = bplis_pkg::BPLIS_SEQ_FETCH_OP;
            else
              next_wait_cnt = wait_cnt - 8'h01;
          end
        end
        default:
          next_seq = bplis_pkg::BPLIS_SEQ_FETCH_OP;
      endcase
    end
  end

  // Pins
  always_comb
  begin
    if (push_pull)
    begin
      next_line_oe  = 1'b1;
      next_line_out = !(tx_pulse_low && tx_allowed);
    end
    else
    begin
      next_line_oe  = tx_pulse_low && tx_allowed;
      next_line_out = 1'b0;
    end
    // never driven against a grounded strap
    next_aux_oe  = backplane && !strap_gnd;
    next_aux_out = (bit_cnt < 16'(BIT_CYC / 2));
    next_drv_en  = hi_pol ? (tx_busy && tx_allowed) : !(tx_busy && tx_allowed);
    if (rst)
    begin
      next_line_oe  = 1'b0;
      next_line_out = 1'b1;
      next_aux_oe   = 1'b0;
      next_aux_out  = 1'b1;
      next_drv_en   = aux_clock_in;
    end
  end

  always_ff @(posedge clock)
  begin
    strap_gnd         <= next_strap_gnd;
    line_drive_out    <= next_line_out;
    line_drive_oe     <= next_line_oe;
    aux_clock_out     <= next_aux_out;
    aux_clock_oe      <= next_aux_oe;
    driver_enable_out <= next_drv_en;
    if (rst)
    begin
      node_control       <= `BPLIS_NC_RESET;
      link_options       <= `BPLIS_LO_RESET;
      irq_status         <= 3'h0;
      irq_mask           <= `BPLIS_MASK_RESET;
      recon_limit        <= `BPLIS_RECON_RESET;
      self_reconfig_flag <= 1'b0;
      rx_activity        <= 1'b0;
      tx_byte            <= 8'h00;
      bit_cnt            <= 16'h0000;
      fast_cnt           <= 16'h0000;
      slow_phase         <= 1'b0;
      pc                 <= 10'h000;
      opcode_reg         <= 8'h00;
      imm_reg            <= 8'h00;
      wait_cnt           <= 8'h00;
      recon_cnt          <= 16'h0000;
      seq                <= bplis_pkg::BPLIS_SEQ_FETCH_OP;
    end
    else
    begin
      node_control       <= next_node_control;
      link_options       <= next_link_options;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      recon_limit        <= next_recon_limit;
      self_reconfig_flag <= next_self_reconfig_flag;
      rx_activity        <= next_rx_activity;
      tx_byte            <= next_tx_byte;
      bit_cnt            <= next_bit_cnt;
      fast_cnt           <= next_fast_cnt;
      slow_phase         <= next_slow_phase;
      pc                 <= next_pc;
      opcode_reg         <= next_opcode_reg;
      imm_reg            <= next_imm_reg;
      wait_cnt           <= next_wait_cnt;
      recon_cnt          <= next_recon_cnt;
      seq                <= next_seq;
    end
  end

endmodule

//--- verif/bplis_top_properties.sv
/*
  Port-level checks of the line interface top, bound into it.
  Assumes backplane mode stays set while enable polarity is judged.
*/
`timescale 1ns/10ps
module bplis_top_properties #(
  parameter int unsigned PULSE_CYC = 160,
  parameter int unsigned BIT_CYC   = 320,
  parameter int unsigned FAST_CYC  = 160
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        line_drive_out,
  input wire logic        line_drive_oe,
  input wire logic        line_receive_in,
  input wire logic        aux_clock_out,
  input wire logic        aux_clock_oe,
  input wire logic        aux_clock_in,
  input wire logic        driver_enable_out
);
  localparam int HALF = BIT_CYC / 2;
  logic        low_q;
  logic        strap_gnd;
  logic [15:0] low_run;
  logic [15:0] gap;
  wire         line_low = line_drive_oe && !line_drive_out;
  wire         en_on    = strap_gnd ? driver_enable_out : !driver_enable_out;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Gap saturates so a first pulse after reset never looks too close
  always_ff @(posedge clock)
  begin
    low_q <= line_low;
    if (rst)
    begin
      low_run   <= 16'h0000;
      gap       <= 16'hFFFF;
      strap_gnd <= !aux_clock_in;
    end
    else
    begin
      low_run <= line_low ? low_run + 16'h0001 : 16'h0000;
      gap     <= (line_low && !low_q) ? 16'h0001 : gap + {15'h0000, gap != 16'hFFFF};
    end
  end

  a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
    rst ##1 rst |-> !line_drive_oe && line_drive_out && !aux_clock_oe
                    && driver_enable_out == aux_clock_in)
    else $error("outputs active during reset");
  a_pulse_width: assert property (!line_low && low_q |-> low_run == PULSE_CYC)
    else $error("drive pulse width wrong");
  a_pulse_spacing: assert property (line_low && !low_q |-> gap >= BIT_CYC)
    else $error("drive pulses closer than one interval");
  a_pulse_enabled: assert property (line_low |-> en_on)
    else $error("pulse while driver enable inactive");
  a_aux_toggles: assert property (aux_clock_oe |-> ##[1:HALF] ($changed(aux_clock_out)
    || !aux_clock_oe))
    else $error("aux clock stalled");
  a_aux_strapped: assert property (strap_gnd |-> !aux_clock_oe)
    else $error("aux pin driven while strapped");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_bad_addr: assert property (psel && penable && (paddr[1:0] != 2'h0
    || !(paddr[7:2] inside {6'h01, [6'h06:6'h0D]})) |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind bplis_top bplis_top_properties #(.PULSE_CYC(PULSE_CYC), .BIT_CYC(BIT_CYC),
  .FAST_CYC(FAST_CYC)) u_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .line_drive_out(line_drive_out),
  .line_drive_oe(line_drive_oe), .line_receive_in(line_receive_in),
  .aux_clock_out(aux_clock_out), .aux_clock_oe(aux_clock_oe),
  .aux_clock_in(aux_clock_in), .driver_enable_out(driver_enable_out));

//--- verif/bplis_media_model.sv
/*
  Shared backplane line with one pull-up, and the strap on the aux pin.
  Assumes the drive pin is looped straight back to the receive pin.
*/
`timescale 1ns/10ps
module bplis_media_model (
  input  wire logic line_drive_out,
  input  wire logic line_drive_oe,
  input  wire logic aux_clock_out,
  input  wire logic aux_clock_oe,
  input  wire logic strap_gnd,
  output logic      line_receive_in,
  output logic      aux_clock_in
);
  // strap stays grounded for good; ground wins over the pin
  // Undriven pin, unknown enable before the first edge included, reads the pull-up
  assign aux_clock_in = strap_gnd ? 1'b0 : (aux_clock_oe === 1'b1 ? aux_clock_out : 1'b1);
  // Released line is pulled high, any low driver wins
  assign line_receive_in = !(line_drive_oe && !line_drive_out);
endmodule

//--- verif/bplis_top_tb.sv
/*
  Self-checking bench: APB registers, loopback transmit and receive, strap.
  Assumes the short timing parameters given at the instance.
*/
`timescale 1ns/10ps
`include "bplis_defines.svh"
module bplis_top_tb;
  localparam int unsigned BIT = 8;
  logic        clock, rst, psel, penable, pwrite, strap_gnd, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, irq, d_out, d_oe, rx_in, a_out, a_oe, a_in, den;
  int          failures = 0, checked = 0, cycles = 0, pulses = 0;

  bplis_top #(.PULSE_CYC(4), .BIT_CYC(BIT), .FAST_CYC(4)) dut (.clock(clock),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .line_drive_out(d_out), .line_drive_oe(d_oe), .line_receive_in(rx_in),
    .aux_clock_out(a_out), .aux_clock_oe(a_oe), .aux_clock_in(a_in),
    .driver_enable_out(den));
  bplis_media_model media (.line_drive_out(d_out), .line_drive_oe(d_oe),
    .aux_clock_out(a_out), .aux_clock_oe(a_oe), .strap_gnd(strap_gnd),
    .line_receive_in(rx_in), .aux_clock_in(a_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge rx_in) pulses++;

  // Whole run needs well under this many cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      @(posedge clock);
    end
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Start a byte, look at the enable two cycles after the write, then poll busy until clear
  task automatic send(input logic [7:0] d, input logic exp_den);
    apb(1'b1, `BPLIS_IDX_TX_DATA, {24'h0, d});
    repeat (2) @(posedge clock);
    check({31'h0, den}, {31'h0, exp_den});
    apb(1'b0, `BPLIS_IDX_TX_DATA, 32'h0);
    for (int n = 0; n < 60 && rdata[8] !== 1'b0; n++) apb(1'b0, `BPLIS_IDX_TX_DATA, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap_gnd = 1'b0;
    repeat (20) @(posedge clock);
    check({28'h0, d_oe, d_out, a_oe, den}, 32'h5);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, `BPLIS_IDX_NODE_CTRL, 32'h0);
    check(rdata, {24'h0, `BPLIS_NC_RESET});
    apb(1'b0, `BPLIS_IDX_LINK_OPT, 32'h0);
    check(rdata, {24'h0, `BPLIS_LO_RESET});
    apb(1'b0, `BPLIS_IDX_RECON_LIM, 32'h0);
    check(rdata, {24'h0, `BPLIS_RECON_RESET});
    apb(1'b0, 6'h3F, 32'h0);
    check({31'h0, last_err}, 32'h1);
    $display("Test reset values done");
    apb(1'b1, `BPLIS_IDX_IRQ_MASK, 32'h3);
    apb(1'b1, `BPLIS_IDX_NODE_CTRL, 32'h24);
    check({31'h0, a_oe}, 32'h1);
    send(8'hA5, 1'b0);
    check(pulses, 32'h4);
    for (int n = 0; n < 20 && rdata[1] !== 1'b1; n++) apb(1'b0, `BPLIS_IDX_IRQ_STAT, 32'h0);
    apb(1'b0, `BPLIS_IDX_RX_DATA, 32'h0);
    check(rdata, 32'hA5);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `BPLIS_IDX_IRQ_STAT, 32'h7);
    check({31'h0, irq}, 32'h0);
    $display("Test open-drain loopback done");
    apb(1'b1, `BPLIS_IDX_LINK_OPT, 32'h80);
    // Pin register follows the style bit one edge after the write
    @(posedge clock);
    check({31'h0, d_oe}, 32'h1);
    send(8'h03, 1'b0);
    check(pulses, 32'h6);
    apb(1'b1, `BPLIS_IDX_NODE_CTRL, 32'h04);
    apb(1'b1, `BPLIS_IDX_TX_DATA, 32'hFF);
    repeat (3 * BIT) @(posedge clock);
    check(pulses, 32'h6);
    check({31'h0, den}, 32'h1);
    $display("Test push-pull and enable gating done");
    strap_gnd <= 1'b1;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b1, `BPLIS_IDX_NODE_CTRL, 32'h24);
    check({31'h0, a_oe}, 32'h0);
    send(8'h01, 1'b1);
    $display("Test grounded strap done");
    apb(1'b1, `BPLIS_IDX_RECON_LIM, 32'h1);
    apb(1'b1, `BPLIS_IDX_IRQ_MASK, 32'h4);
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clock);
    apb(1'b0, `BPLIS_IDX_DIAG, 32'h0);
    check({31'h0, rdata[7]}, 32'h1);
    apb(1'b0, `BPLIS_IDX_DIAG, 32'h0);
    check({31'h0, rdata[7]}, 32'h0);
    $display("Test reconfiguration done");
    report_and_stop();
  end
endmodule
